// File: common/bms_pkg.sv
// constants and types for the basic mode status register and its management slave
package bms_pkg;
  // bit positions of the basic mode status word
  localparam int BIT_T4 = 15;
  localparam int BIT_TX_FD = 14;
  localparam int BIT_TX_HD = 13;
  localparam int BIT_TE_FD = 12;
  localparam int BIT_TE_HD = 11;
  localparam int BIT_T2_FD = 10;
  localparam int BIT_T2_HD = 9;
  localparam int BIT_EXT_STATUS = 8;
  localparam int BIT_RESERVED = 7;
  localparam int BIT_PREAMBLE_SKIP = 6;
  localparam int BIT_AN_COMPLETE = 5;
  localparam int BIT_REMOTE_FAULT = 4;
  localparam int BIT_AN_ABILITY = 3;
  localparam int BIT_LINK_STATUS = 2;
  localparam int BIT_JABBER = 1;
  localparam int BIT_EXT_CAPABILITY = 0;
  // management register address of this register
  localparam logic [4:0] REG_BASIC_MODE_STATUS = 5'h01;
  // management frame fields
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [4:0] OP_LAST = 5'h01;
  localparam logic [4:0] ADDR_LAST = 5'h09;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef struct packed {
    logic link_good;
    logic an_complete;
    logic remote_fault;
    logic jabber;
    logic speed_10;
  } bms_events_t;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_START,
    ST_OP,
    ST_ADDR,
    ST_TA,
    ST_DATA
  } bms_state_t;
endpackage

// File: core/bms_status_reg.sv
// basic mode status register with its serial management slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - bit 15 always reads 0, no T4
// - bits 14,13 always read 1, TX duplexes
// - bits 12,11 always read 1, Te duplexes
// - bits 10,9 always read 0, no T2
// - bit 8 reads 1, extended status present
// - bit 7 reserved, reads 0, write 0
// - bit 6 reads 1, preamble may be skipped
// - bit 5 shows negotiation done, resets 0
// - bit 4 latches on remote fault event
// - remote fault clears on read or reset
// - bit 3 reads 1, negotiation capable
// - bit 2 link, cleared by any failure
// - link returns only after read while good
// - bit 1 jabber, set only at 10M
// - jabber latched until read or reset
// - bit 0 reads 1, extended registers
// - fixed bits ignore writes, keep value
module bms_status_reg #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  input wire bms_pkg::bms_events_t ev_in,
  output logic [15:0] status_out
);

  logic mdc_s1;
  logic mdc_s2;
  logic mdc_s3;
  logic mdio_s1;
  logic mdio_s2;
  logic mdc_rise;
  logic bit_in;

  bms_pkg::bms_state_t state;
  logic [4:0] bit_cnt;
  logic [5:0] ones_cnt;
  logic [9:0] shift_in;
  logic [9:0] addr_full;
  logic [15:0] out_shift;
  logic need_pre;
  logic is_read;
  logic sel;
  logic snap;
  logic read_done;
  logic reg_hit;
  logic reg_match;

  logic an_done;
  logic remote_fault;
  logic remote_fault_new;
  logic jabber;
  logic jabber_new;
  logic link_up;
  logic link_fail_new;
  logic jabber_event;
  logic [15:0] status_word;

  // pins from the management master are asynchronous to clk_in
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mdc_s1 <= 1'b0;
      mdc_s2 <= 1'b0;
      mdc_s3 <= 1'b0;
      mdio_s1 <= 1'b1;
      mdio_s2 <= 1'b1;
    end else begin
      mdc_s1 <= mdc_in;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= mdio_in;
      mdio_s2 <= mdio_s1;
    end
  end

  assign mdc_rise = mdc_s2 & ~mdc_s3;
  assign bit_in = mdio_s2;
  assign addr_full = {shift_in[8:0], bit_in};
  // register field of the address shift, valid at the last address bit
  assign reg_match = (addr_full[4:0] == bms_pkg::REG_BASIC_MODE_STATUS);
  // jabber has meaning only in 10 Mb/s operation
  assign jabber_event = ev_in.jabber & ev_in.speed_10;

  // the word is built from constants and the status latches, so bus writes can never alter it
  always_comb begin
    status_word = bms_pkg::WORD_ZERO;
    status_word[bms_pkg::BIT_T4] = 1'b0;
    status_word[bms_pkg::BIT_TX_FD] = 1'b1;
    status_word[bms_pkg::BIT_TX_HD] = 1'b1;
    status_word[bms_pkg::BIT_TE_FD] = 1'b1;
    status_word[bms_pkg::BIT_TE_HD] = 1'b1;
    status_word[bms_pkg::BIT_T2_FD] = 1'b0;
    status_word[bms_pkg::BIT_T2_HD] = 1'b0;
    status_word[bms_pkg::BIT_EXT_STATUS] = 1'b1;
    status_word[bms_pkg::BIT_RESERVED] = 1'b0;
    status_word[bms_pkg::BIT_PREAMBLE_SKIP] = 1'b1;
    status_word[bms_pkg::BIT_AN_COMPLETE] = an_done;
    status_word[bms_pkg::BIT_REMOTE_FAULT] = remote_fault;
    status_word[bms_pkg::BIT_AN_ABILITY] = 1'b1;
    status_word[bms_pkg::BIT_LINK_STATUS] = link_up;
    status_word[bms_pkg::BIT_JABBER] = jabber;
    status_word[bms_pkg::BIT_EXT_CAPABILITY] = 1'b1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      an_done <= 1'b0;
    end else begin
      an_done <= ev_in.an_complete;
    end
  end

  // events after the snapshot must survive the clear at read end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      remote_fault <= 1'b0;
      remote_fault_new <= 1'b0;
    end else begin
      if (read_done) begin
        remote_fault <= remote_fault_new | ev_in.remote_fault;
      end else if (ev_in.remote_fault) begin
        remote_fault <= 1'b1;
      end
      if (snap) begin
        remote_fault_new <= ev_in.remote_fault;
      end else if (ev_in.remote_fault) begin
        remote_fault_new <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      jabber <= 1'b0;
      jabber_new <= 1'b0;
    end else begin
      if (read_done) begin
        jabber <= jabber_new | jabber_event;
      end else if (jabber_event) begin
        jabber <= 1'b1;
      end
      if (snap) begin
        jabber_new <= jabber_event;
      end else if (jabber_event) begin
        jabber_new <= 1'b1;
      end
    end
  end

  // a failure since the snapshot keeps the bit low after that read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_up <= 1'b0;
      link_fail_new <= 1'b0;
    end else begin
      if (read_done) begin
        link_up <= ev_in.link_good & ~link_fail_new;
      end else if (!ev_in.link_good) begin
        link_up <= 1'b0;
      end
      if (snap) begin
        link_fail_new <= ~ev_in.link_good;
      end else if (!ev_in.link_good) begin
        link_fail_new <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_out <= bms_pkg::WORD_ZERO;
    end else begin
      status_out <= status_word;
    end
  end

  // frame engine; mdc must be well below clk_in/4 for the synchroniser
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= bms_pkg::ST_HUNT;
      bit_cnt <= 5'h00;
      ones_cnt <= 6'h00;
      shift_in <= 10'h000;
      need_pre <= 1'b1;
      is_read <= 1'b0;
      sel <= 1'b0;
      reg_hit <= 1'b0;
      snap <= 1'b0;
      read_done <= 1'b0;
    end else begin
      snap <= 1'b0;
      read_done <= 1'b0;
      if (mdc_rise) begin
        case (state)
          bms_pkg::ST_HUNT: begin
            if (bit_in) begin
              if (ones_cnt != bms_pkg::PREAMBLE_ONES) begin
                ones_cnt <= ones_cnt + 6'h01;
              end
              if (ones_cnt == bms_pkg::PREAMBLE_ONES - 6'h01) begin
                need_pre <= 1'b0;
              end
            end else begin
              ones_cnt <= 6'h00;
              // a start without preamble is taken once one has been seen
              if (!need_pre) begin
                state <= bms_pkg::ST_START;
              end
            end
          end
          bms_pkg::ST_START: begin
            bit_cnt <= 5'h00;
            state <= bit_in ? bms_pkg::ST_OP : bms_pkg::ST_HUNT;
          end
          bms_pkg::ST_OP: begin
            shift_in <= addr_full;
            if (bit_cnt == bms_pkg::OP_LAST) begin
              bit_cnt <= 5'h00;
              if ({shift_in[0], bit_in} == bms_pkg::OP_READ) begin
                is_read <= 1'b1;
                state <= bms_pkg::ST_ADDR;
              end else if ({shift_in[0], bit_in} == bms_pkg::OP_WRITE) begin
                is_read <= 1'b0;
                state <= bms_pkg::ST_ADDR;
              end else begin
                need_pre <= 1'b1;
                state <= bms_pkg::ST_HUNT;
              end
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          bms_pkg::ST_ADDR: begin
            shift_in <= addr_full;
            if (bit_cnt == bms_pkg::ADDR_LAST) begin
              bit_cnt <= 5'h00;
              sel <= (addr_full[9:5] == PHY_ADDR);
              state <= bms_pkg::ST_TA;
              // other registers and other phys leave the latches alone
              reg_hit <= is_read && (addr_full[9:5] == PHY_ADDR) && reg_match;
              if (is_read && (addr_full[9:5] == PHY_ADDR) && reg_match) begin
                snap <= 1'b1;
              end
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          bms_pkg::ST_TA: begin
            if (bit_cnt == 5'h00) begin
              shift_in <= addr_full;
              bit_cnt <= 5'h01;
            end else begin
              bit_cnt <= 5'h00;
              if (!is_read && {shift_in[0], bit_in} != bms_pkg::TA_WRITE) begin
                need_pre <= 1'b1;
                state <= bms_pkg::ST_HUNT;
              end else begin
                state <= bms_pkg::ST_DATA;
              end
            end
          end
          bms_pkg::ST_DATA: begin
            // write data is clocked past and dropped
            if (bit_cnt == bms_pkg::DATA_LAST) begin
              bit_cnt <= 5'h00;
              state <= bms_pkg::ST_HUNT;
              if (reg_hit) begin
                read_done <= 1'b1;
              end
            end else begin
              bit_cnt <= bit_cnt + 5'h01;
            end
          end
          default: begin
            state <= bms_pkg::ST_HUNT;
          end
        endcase
      end
    end
  end

  // pin driver kept apart so the drive timing reads on its own
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_shift <= bms_pkg::WORD_ZERO;
      mdio_out <= 1'b0;
      mdio_oe_out <= 1'b0;
    end else if (mdc_rise) begin
      case (state)
        bms_pkg::ST_ADDR: begin
          // the latched value goes out; clearing waits for read end
          if (bit_cnt == bms_pkg::ADDR_LAST) begin
            if (reg_match) begin
              out_shift <= status_word;
            end else begin
              out_shift <= bms_pkg::WORD_ZERO;
            end
          end
        end
        bms_pkg::ST_TA: begin
          if (is_read && sel) begin
            // first turnaround bit: take the line and hold it low
            if (bit_cnt == 5'h00) begin
              mdio_oe_out <= 1'b1;
              mdio_out <= 1'b0;
            end else begin
              mdio_out <= out_shift[15];
              out_shift <= {out_shift[14:0], 1'b0};
            end
          end
        end
        bms_pkg::ST_DATA: begin
          if (bit_cnt == bms_pkg::DATA_LAST) begin
            mdio_oe_out <= 1'b0;
            mdio_out <= 1'b0;
          end else if (is_read && sel) begin
            mdio_out <= out_shift[15];
            out_shift <= {out_shift[14:0], 1'b0};
          end
        end
        default: begin
          // nothing drives outside the read phases
          mdio_oe_out <= 1'b0;
          mdio_out <= 1'b0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// File: dv/bms_status_reg_asserts.sv
// port assertions for the basic mode status register
`timescale 1ns/1ps
`default_nettype none
module bms_status_reg_asserts (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_out,
  input wire bms_pkg::bms_events_t ev_in,
  input wire logic [15:0] status_out
);
  logic [3:0] oe_hist;
  logic jab_ev;
  // remote fault may only drop, or link rise, just after a driven read ends
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_hist <= 4'h0;
    end else begin
      oe_hist <= {oe_hist[2:0], mdio_oe_out};
    end
  end
  assign jab_ev = ev_in.jabber & ev_in.speed_10;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence an_steady;
    $stable(ev_in.an_complete) [*3];
  endsequence
  sequence read_done;
    (|oe_hist) && !mdio_oe_out;
  endsequence
  AST_FIXED: assert property (!$past(rst_in) |-> (status_out & 16'hffc9) == 16'h7949)
    else $error("fixed bits wrong");
  AST_AN: assert property (an_steady |=> status_out[5] == $past(ev_in.an_complete))
    else $error("negotiation bit wrong");
  AST_RF_SET: assert property (ev_in.remote_fault |-> ##[1:3] status_out[4])
    else $error("remote fault not latched");
  AST_RF_CLR: assert property ($fell(status_out[4]) |-> read_done)
    else $error("remote fault dropped without read");
  AST_JAB_SET: assert property (jab_ev |-> ##[1:3] status_out[1])
    else $error("jabber not latched");
  AST_JAB_ONLY: assert property ($rose(status_out[1]) |-> $past(jab_ev) || $past(jab_ev, 2))
    else $error("jabber set without cause");
  AST_LINK_DROP: assert property (!ev_in.link_good |-> ##[1:3] !status_out[2])
    else $error("link bit not cleared");
  AST_LINK_SET: assert property ($rose(status_out[2]) |-> read_done)
    else $error("link bit set without read");
endmodule
`default_nettype wire

// File: dv/bms_mdio_master.sv
// station management controller model on the management pins
`timescale 1ns/1ps
`default_nettype none
module bms_mdio_master (
  input wire logic clk_in,
  input wire logic line_in,
  output logic mdc_out,
  output logic md_out,
  output logic md_oe_out
);
  initial begin
    mdc_out = 1'b0;
    md_out = 1'b1;
    md_oe_out = 1'b0;
  end
  // 12 clk per mdc period so a slave bit settles before the next rise
  task automatic tick(input logic oe, input logic b, output logic s);
    repeat (6) @(posedge clk_in);
    mdc_out <= 1'b0;
    md_oe_out <= oe;
    md_out <= b;
    repeat (6) @(posedge clk_in);
    mdc_out <= 1'b1;
    s = line_in;
  endtask
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [31:0] f;
    f = {2'b01, op, pa, ra, bms_pkg::TA_WRITE, wd};
    rd = bms_pkg::WORD_ZERO;
    for (int i = 0; i < 32; i++) begin
      if (pre) tick(1'b1, 1'b1, s);
    end
    for (int i = 31; i >= 0; i--) begin
      tick(!(op == bms_pkg::OP_READ && i < 18), f[i], s);
      if (i < 16) rd[i] = s;
    end
    tick(1'b0, 1'b1, s);
    repeat (6) @(posedge clk_in);
    mdc_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/bms_status_reg_tb.sv
// self-checking bench for the basic mode status register
`timescale 1ns/1ps
`default_nettype none
module bms_status_reg_tb;
  logic clk_in;
  logic rst_in;
  logic mdc;
  logic md;
  logic md_oe;
  logic mdio_out;
  logic mdio_oe_out;
  logic line;
  bms_pkg::bms_events_t ev;
  logic [15:0] status_out;
  logic [15:0] rd;
  logic rf, jb, lk, an;
  logic [31:0] r;
  int fail_count;
  int n_tests;
  // pull-up on the shared data line
  assign line = mdio_oe_out ? mdio_out : (md_oe ? md : 1'b1);
  bms_status_reg dut (.clk_in(clk_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(line),
    .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out), .ev_in(ev), .status_out(status_out));
  bms_mdio_master mst (.clk_in(clk_in), .line_in(line), .mdc_out(mdc), .md_out(md),
    .md_oe_out(md_oe));
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  function automatic logic [15:0] model();
    return 16'h7949 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_in);
    check("status", status_out, model());
  endtask
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd);
    mst.frame(pre, op, pa, ra, wd, rd);
  endtask
  task automatic rdreg(input logic pre);
    frame(pre, bms_pkg::OP_READ, 5'h00, bms_pkg::REG_BASIC_MODE_STATUS, 16'h0000);
    check("read", rd, model());
    rf = 1'b0;
    jb = 1'b0;
    lk = ev.link_good;
    settle();
  endtask
  // one-cycle event burst, then link good again with negotiation kept
  task automatic pulse(input logic [4:0] e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= {1'b1, e[3], 3'b000};
    lk = lk & e[4];
    rf = rf | e[2];
    jb = jb | (e[1] & e[0]);
    an = e[3];
    settle();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_in);
    fail_count++;
    complete_run();
  end
  initial begin
    fail_count = 0;
    n_tests = 0;
    {rf, jb, lk, an} = 4'h0;
    rst_in = 1'b1;
    ev = 5'b10000;
    r = $urandom(5);
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    settle();
    rdreg(1'b1);
    rdreg(1'b0);
    pulse(5'b10100);
    r = $urandom;
    frame(1'b0, bms_pkg::OP_WRITE, 5'h00, 5'h01, r[15:0] & 16'hff7f);
    settle();
    for (int i = 0; i < 14; i++) begin
      r = $urandom;
      pulse(r[4:0]);
      rdreg(1'b0);
    end
    pulse(5'b10111);
    frame(1'b0, bms_pkg::OP_READ, 5'h15, 5'h01, 16'h0000);
    check("other phy", rd, 16'hffff);
    frame(1'b0, bms_pkg::OP_READ, 5'h00, 5'h0f, 16'h0000);
    check("unmapped", rd, 16'h0000);
    settle();
    frame(1'b0, 2'b11, 5'h00, 5'h01, 16'h0000);
    frame(1'b0, bms_pkg::OP_READ, 5'h00, 5'h01, 16'h0000);
    check("no preamble", rd, 16'hffff);
    rdreg(1'b1);
    pulse(5'b00111);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    {rf, jb, lk} = 3'h0;
    settle();
    rdreg(1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
bind bms_status_reg bms_status_reg_asserts chk (.clk_in(clk_in), .rst_in(rst_in),
  .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out),
  .ev_in(ev_in), .status_out(status_out));
